// File: verilog/irq_flag_pkg.sv
package irq_flag_pkg;
    localparam int ADDR_W = 4;
    localparam int NUM_FLAG_REGS = 4;
    // register offsets
    localparam logic [3:0] CLOCK_ADC_FLAGS_OFS = 4'h0;
    localparam logic [3:0] ANALOG_EVENT_FLAGS_OFS = 4'h1;
    localparam logic [3:0] SERIAL_COMM_FLAGS_OFS = 4'h2;
    localparam logic [3:0] TIMER_EVENT_FLAGS_OFS = 4'h3;
    localparam logic [3:0] ENABLE_BASE_OFS = 4'h4;
    localparam logic [3:0] IRQ_CONTROL_OFS = 4'h8;
    localparam logic [3:0] TX_SHIFT_STATUS_OFS = 4'h9;
    // bit positions
    localparam int OSC_FAILSAFE_BIT = 7;
    localparam int CLOCK_SWITCH_BIT = 6;
    localparam int CONVERSION_DONE_BIT = 0;
    localparam int ZERO_CROSS_BIT = 6;
    localparam int COMPARATOR_TWO_BIT = 1;
    localparam int COMPARATOR_ONE_BIT = 0;
    localparam int UART_TWO_RX_BIT = 7;
    localparam int UART_TWO_TX_BIT = 6;
    localparam int UART_ONE_RX_BIT = 5;
    localparam int UART_ONE_TX_BIT = 4;
    localparam int SYNC_TWO_COLLISION_BIT = 3;
    localparam int SYNC_TWO_DONE_BIT = 2;
    localparam int SYNC_ONE_COLLISION_BIT = 1;
    localparam int SYNC_ONE_DONE_BIT = 0;
    localparam int TIMER_TWO_EVENT_BIT = 1;
    localparam int TIMER_ONE_OVERFLOW_BIT = 0;
    localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
    localparam int UART_TWO_SHIFT_EMPTY_BIT = 1;
    localparam int UART_ONE_SHIFT_EMPTY_BIT = 0;
    // writable, hardware-set bits of each flag register
    localparam logic [3:0][7:0] STICKY_MASK = {8'h03, 8'h0F, 8'h43, 8'hC1};
    // bits that exist at all (sticky plus read-only levels)
    localparam logic [3:0][7:0] IMPL_MASK = {8'h03, 8'hFF, 8'h43, 8'hC1};
    localparam logic [7:0] IRQ_CONTROL_MASK = 8'hC0;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    typedef struct packed {
        logic [3:0][7:0] flag;
        logic [3:0][7:0] enable;
        logic [7:0] control;
        logic [7:0] rdata;
        logic irq_req;
    } flag_bank_s;
endpackage : irq_flag_pkg

// File: verilog/peripheral_irq_flag_bank.sv
`timescale 1ns/10ps
module peripheral_irq_flag_bank
    import irq_flag_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic osc_failsafe_event,
    input wire logic clock_switch_ready,
    input wire logic conversion_done,
    input wire logic zero_cross_event,
    input wire logic comparator_two_event,
    input wire logic comparator_one_event,
    input wire logic uart_two_rx_not_empty,
    input wire logic uart_two_tx_has_space,
    input wire logic uart_one_rx_not_empty,
    input wire logic uart_one_tx_has_space,
    input wire logic uart_two_shift_empty,
    input wire logic uart_one_shift_empty,
    input wire logic sync_two_collision,
    input wire logic sync_two_done,
    input wire logic sync_one_collision,
    input wire logic sync_one_done,
    input wire logic timer_two_event,
    input wire logic timer_one_overflow,
    output logic periph_irq_req
);

    flag_bank_s st_ff;
    flag_bank_s nxt_st;
    logic [3:0][7:0] set_evt;
    logic [3:0][7:0] flag_view;
    logic [7:0] tx_shift_view;
    logic [7:0] rd_mux;
    logic irq_any;

    // hardware set requests, one byte per flag register
    always_comb
    begin
        set_evt = '0;
        set_evt[0][OSC_FAILSAFE_BIT] = osc_failsafe_event;
        set_evt[0][CLOCK_SWITCH_BIT] = clock_switch_ready;
        set_evt[0][CONVERSION_DONE_BIT] = conversion_done;
        set_evt[1][ZERO_CROSS_BIT] = zero_cross_event;
        set_evt[1][COMPARATOR_TWO_BIT] = comparator_two_event;
        set_evt[1][COMPARATOR_ONE_BIT] = comparator_one_event;
        set_evt[2][SYNC_TWO_COLLISION_BIT] = sync_two_collision;
        set_evt[2][SYNC_ONE_COLLISION_BIT] = sync_one_collision;
        set_evt[2][SYNC_TWO_DONE_BIT] = sync_two_done;
        set_evt[2][SYNC_ONE_DONE_BIT] = sync_one_done;
        set_evt[3][TIMER_TWO_EVENT_BIT] = timer_two_event;
        set_evt[3][TIMER_ONE_OVERFLOW_BIT] = timer_one_overflow;
    end

    // uart levels are not stored: they follow the buffers, so only the uart
    // itself can clear them by draining or filling its buffer
    always_comb
    begin
        flag_view = st_ff.flag;
        flag_view[2][UART_TWO_RX_BIT] = uart_two_rx_not_empty;
        flag_view[2][UART_ONE_RX_BIT] = uart_one_rx_not_empty;
        flag_view[2][UART_TWO_TX_BIT] = uart_two_tx_has_space;
        flag_view[2][UART_ONE_TX_BIT] = uart_one_tx_has_space;
        tx_shift_view = '0;
        tx_shift_view[UART_TWO_SHIFT_EMPTY_BIT] = uart_two_shift_empty;
        tx_shift_view[UART_ONE_SHIFT_EMPTY_BIT] = uart_one_shift_empty;
    end

    always_comb
    begin
        rd_mux = 8'h00;
        for (int i = 0; i < NUM_FLAG_REGS; i++)
        begin
            if (addr == CLOCK_ADC_FLAGS_OFS + 4'(i))
            begin
                rd_mux = flag_view[i] & IMPL_MASK[i];
            end
            if (addr == ENABLE_BASE_OFS + 4'(i))
            begin
                rd_mux = st_ff.enable[i] & IMPL_MASK[i];
            end
        end
        if (addr == IRQ_CONTROL_OFS)
        begin
            rd_mux = st_ff.control;
        end
        if (addr == TX_SHIFT_STATUS_OFS)
        begin
            rd_mux = tx_shift_view;
        end
    end

    always_comb
    begin
        irq_any = 1'b0;
        for (int i = 0; i < NUM_FLAG_REGS; i++)
        begin
            irq_any = irq_any | (|(flag_view[i] & st_ff.enable[i] & IMPL_MASK[i]));
        end
    end

    always_comb
    begin
        nxt_st = st_ff;
        for (int i = 0; i < NUM_FLAG_REGS; i++)
        begin
            if (wr && addr == CLOCK_ADC_FLAGS_OFS + 4'(i))
            begin
                nxt_st.flag[i] = wdata & STICKY_MASK[i];
            end
            if (wr && addr == ENABLE_BASE_OFS + 4'(i))
            begin
                nxt_st.enable[i] = wdata & IMPL_MASK[i];
            end
            // or-ing after the write lets a set survive a same-cycle clear
            nxt_st.flag[i] = nxt_st.flag[i] | (set_evt[i] & STICKY_MASK[i]);
        end
        if (wr && addr == IRQ_CONTROL_OFS)
        begin
            nxt_st.control = wdata & IRQ_CONTROL_MASK;
        end
        // data only in the cycle after the read strobe, zero otherwise
        nxt_st.rdata = rd ? rd_mux : 8'h00;
        nxt_st.irq_req = irq_any && st_ff.control[PERIPHERAL_IRQ_ENABLE_BIT]
            && st_ff.control[GLOBAL_IRQ_ENABLE_BIT];
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            st_ff.flag <= {NUM_FLAG_REGS{FLAG_RESET}};
            st_ff.enable <= {NUM_FLAG_REGS{ENABLE_RESET}};
            st_ff.control <= CONTROL_RESET;
            st_ff.rdata <= 8'h00;
            st_ff.irq_req <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign rdata = st_ff.rdata;
    assign periph_irq_req = st_ff.irq_req;

    // checks
    sequence s_osc_event;
        osc_failsafe_event;
    endsequence

    sequence s_osc_latched;
        st_ff.flag[0][OSC_FAILSAFE_BIT] ##1 st_ff.flag[0][OSC_FAILSAFE_BIT];
    endsequence

    // flag caught and held while no write touches register 0
    a_osc_latch_hold: assert property (@(posedge clk) disable iff (!rstn)
        s_osc_event ##0 !(wr && addr == CLOCK_ADC_FLAGS_OFS) ##1
        !(wr && addr == CLOCK_ADC_FLAGS_OFS) |-> s_osc_latched)
        else $error("oscillator fail-safe flag not held");

    a_flag_sticky: assert property (@(posedge clk) disable iff (!rstn)
        st_ff.flag[2][SYNC_ONE_DONE_BIT] && !(wr && addr == SERIAL_COMM_FLAGS_OFS)
        |=> st_ff.flag[2][SYNC_ONE_DONE_BIT])
        else $error("sync done flag dropped without a write");

    a_set_wins: assert property (@(posedge clk) disable iff (!rstn)
        conversion_done && wr && addr == CLOCK_ADC_FLAGS_OFS
        && !wdata[CONVERSION_DONE_BIT]
        |=> st_ff.flag[0][CONVERSION_DONE_BIT])
        else $error("clear beat a hardware set");

    a_sw_clear: assert property (@(posedge clk) disable iff (!rstn)
        wr && addr == ANALOG_EVENT_FLAGS_OFS && !zero_cross_event
        |=> st_ff.flag[1][ZERO_CROSS_BIT] == $past(wdata[ZERO_CROSS_BIT]))
        else $error("zero-cross flag ignored software write");

    a_unimpl_zero: assert property (@(posedge clk) disable iff (!rstn)
        rd && addr == CLOCK_ADC_FLAGS_OFS |=> (rdata & ~IMPL_MASK[0]) == 8'h00)
        else $error("unimplemented bits read nonzero");

    a_rx_level_read: assert property (@(posedge clk) disable iff (!rstn)
        rd && addr == SERIAL_COMM_FLAGS_OFS
        |=> rdata[UART_ONE_RX_BIT] == $past(uart_one_rx_not_empty)
        && rdata[UART_TWO_TX_BIT] == $past(uart_two_tx_has_space))
        else $error("uart level flags misread");

    a_read_window: assert property (@(posedge clk) disable iff (!rstn)
        !rd |=> rdata == 8'h00)
        else $error("read data outside its cycle");

    a_irq_gated: assert property (@(posedge clk) disable iff (!rstn)
        periph_irq_req |-> $past(st_ff.control[GLOBAL_IRQ_ENABLE_BIT])
        && $past(st_ff.control[PERIPHERAL_IRQ_ENABLE_BIT]))
        else $error("interrupt requested while disabled");

    sequence s_overflow_armed;
        st_ff.flag[3][TIMER_ONE_OVERFLOW_BIT] && st_ff.enable[3][TIMER_ONE_OVERFLOW_BIT]
        && st_ff.control[GLOBAL_IRQ_ENABLE_BIT] && st_ff.control[PERIPHERAL_IRQ_ENABLE_BIT];
    endsequence

    a_irq_raise: assert property (@(posedge clk) disable iff (!rstn)
        s_overflow_armed |=> periph_irq_req)
        else $error("enabled flag gave no interrupt");

    a_set_no_enable: assert property (@(posedge clk) disable iff (!rstn)
        comparator_one_event && !st_ff.enable[1][COMPARATOR_ONE_BIT]
        |=> st_ff.flag[1][COMPARATOR_ONE_BIT])
        else $error("flag not set with enable off");

    a_reset_clear: assert property (@(posedge clk)
        !rstn |=> st_ff.flag == '0 && !periph_irq_req)
        else $error("flags not cleared by reset");

    // one high event cycle is enough; the flag shows from the next edge
    a_clk_switch_set: assert property (@(posedge clk) disable iff (!rstn)
        clock_switch_ready |=> st_ff.flag[0][CLOCK_SWITCH_BIT])
        else $error("clock switch flag not set");

    a_conv_done_set: assert property (@(posedge clk) disable iff (!rstn)
        conversion_done |=> st_ff.flag[0][CONVERSION_DONE_BIT])
        else $error("conversion flag not set");

    a_zero_cross_set: assert property (@(posedge clk) disable iff (!rstn)
        zero_cross_event |=> st_ff.flag[1][ZERO_CROSS_BIT])
        else $error("zero-cross flag not set");

    a_comp_two_set: assert property (@(posedge clk) disable iff (!rstn)
        comparator_two_event |=> st_ff.flag[1][COMPARATOR_TWO_BIT])
        else $error("comparator two flag not set");

    a_sync_two_coll: assert property (@(posedge clk) disable iff (!rstn)
        sync_two_collision |=> st_ff.flag[2][SYNC_TWO_COLLISION_BIT])
        else $error("sync two collision flag not set");

    a_sync_one_coll: assert property (@(posedge clk) disable iff (!rstn)
        sync_one_collision |=> st_ff.flag[2][SYNC_ONE_COLLISION_BIT])
        else $error("sync one collision flag not set");

    a_sync_two_done: assert property (@(posedge clk) disable iff (!rstn)
        sync_two_done |=> st_ff.flag[2][SYNC_TWO_DONE_BIT])
        else $error("sync two done flag not set");

    a_sync_one_done: assert property (@(posedge clk) disable iff (!rstn)
        sync_one_done |=> st_ff.flag[2][SYNC_ONE_DONE_BIT])
        else $error("sync one done flag not set");

    a_timer_two_set: assert property (@(posedge clk) disable iff (!rstn)
        timer_two_event |=> st_ff.flag[3][TIMER_TWO_EVENT_BIT])
        else $error("timer two flag not set");

    a_timer_one_set: assert property (@(posedge clk) disable iff (!rstn)
        timer_one_overflow |=> st_ff.flag[3][TIMER_ONE_OVERFLOW_BIT])
        else $error("timer one flag not set");

    // outside reset, a sticky flag drops only through a write to its own register
    a_clk_switch_hold: assert property (@(posedge clk) disable iff (!rstn)
        st_ff.flag[0][CLOCK_SWITCH_BIT] && !(wr && addr == CLOCK_ADC_FLAGS_OFS)
        |=> st_ff.flag[0][CLOCK_SWITCH_BIT])
        else $error("clock switch flag dropped");

    a_conv_hold: assert property (@(posedge clk) disable iff (!rstn)
        st_ff.flag[0][CONVERSION_DONE_BIT] && !(wr && addr == CLOCK_ADC_FLAGS_OFS)
        |=> st_ff.flag[0][CONVERSION_DONE_BIT])
        else $error("conversion flag dropped");

    a_zero_cross_hold: assert property (@(posedge clk) disable iff (!rstn)
        st_ff.flag[1][ZERO_CROSS_BIT] && !(wr && addr == ANALOG_EVENT_FLAGS_OFS)
        |=> st_ff.flag[1][ZERO_CROSS_BIT])
        else $error("zero-cross flag dropped");

    a_comp_hold: assert property (@(posedge clk) disable iff (!rstn)
        st_ff.flag[1][COMPARATOR_TWO_BIT] && !(wr && addr == ANALOG_EVENT_FLAGS_OFS)
        |=> st_ff.flag[1][COMPARATOR_TWO_BIT])
        else $error("comparator two flag dropped");

    a_collision_hold: assert property (@(posedge clk) disable iff (!rstn)
        st_ff.flag[2][SYNC_TWO_COLLISION_BIT] && !(wr && addr == SERIAL_COMM_FLAGS_OFS)
        |=> st_ff.flag[2][SYNC_TWO_COLLISION_BIT])
        else $error("collision flag dropped");

    a_timer_hold: assert property (@(posedge clk) disable iff (!rstn)
        st_ff.flag[3][TIMER_TWO_EVENT_BIT] && !(wr && addr == TIMER_EVENT_FLAGS_OFS)
        |=> st_ff.flag[3][TIMER_TWO_EVENT_BIT])
        else $error("timer two flag dropped");

    a_overflow_hold: assert property (@(posedge clk) disable iff (!rstn)
        st_ff.flag[3][TIMER_ONE_OVERFLOW_BIT] && !(wr && addr == TIMER_EVENT_FLAGS_OFS)
        |=> st_ff.flag[3][TIMER_ONE_OVERFLOW_BIT])
        else $error("timer one flag dropped");

    a_unimpl_reg1: assert property (@(posedge clk) disable iff (!rstn)
        rd && addr == ANALOG_EVENT_FLAGS_OFS |=> (rdata & ~IMPL_MASK[1]) == 8'h00)
        else $error("analog register unimplemented bits nonzero");

    a_unimpl_reg3: assert property (@(posedge clk) disable iff (!rstn)
        rd && addr == TIMER_EVENT_FLAGS_OFS |=> (rdata & ~IMPL_MASK[3]) == 8'h00)
        else $error("timer register unimplemented bits nonzero");

    a_store_unimpl: assert property (@(posedge clk) disable iff (!rstn)
        (st_ff.flag[0] & ~STICKY_MASK[0]) == 8'h00 && (st_ff.flag[1] & ~STICKY_MASK[1]) == 8'h00
        && (st_ff.flag[3] & ~STICKY_MASK[3]) == 8'h00)
        else $error("unimplemented flag bit stored");

    // the uart levels live only on their inputs, so software cannot fake them
    a_uart_not_stored: assert property (@(posedge clk) disable iff (!rstn)
        (st_ff.flag[2] & ~STICKY_MASK[2]) == 8'h00)
        else $error("uart level flag stored");

    a_tx_level_read: assert property (@(posedge clk) disable iff (!rstn)
        rd && addr == SERIAL_COMM_FLAGS_OFS
        |=> rdata[UART_ONE_TX_BIT] == $past(uart_one_tx_has_space)
        && rdata[UART_TWO_RX_BIT] == $past(uart_two_rx_not_empty))
        else $error("uart space flags misread");

    a_shift_status_read: assert property (@(posedge clk) disable iff (!rstn)
        rd && addr == TX_SHIFT_STATUS_OFS
        |=> rdata[UART_ONE_SHIFT_EMPTY_BIT] == $past(uart_one_shift_empty)
        && rdata[UART_TWO_SHIFT_EMPTY_BIT] == $past(uart_two_shift_empty))
        else $error("shift empty status misread");

    a_irq_no_peripheral_irq_enable: assert property (@(posedge clk) disable iff (!rstn)
        !st_ff.control[PERIPHERAL_IRQ_ENABLE_BIT] |=> !periph_irq_req)
        else $error("interrupt without peripheral enable");

    a_irq_no_gie: assert property (@(posedge clk) disable iff (!rstn)
        !st_ff.control[GLOBAL_IRQ_ENABLE_BIT] |=> !periph_irq_req)
        else $error("interrupt without global enable");

    a_irq_no_enable: assert property (@(posedge clk) disable iff (!rstn)
        st_ff.enable == '0 |=> !periph_irq_req)
        else $error("interrupt with every source disabled");

    a_unmapped_read: assert property (@(posedge clk) disable iff (!rstn)
        rd && addr > TX_SHIFT_STATUS_OFS |=> rdata == 8'h00)
        else $error("unmapped address read nonzero");

    a_control_write: assert property (@(posedge clk) disable iff (!rstn)
        wr && addr == IRQ_CONTROL_OFS |=> st_ff.control == ($past(wdata) & IRQ_CONTROL_MASK))
        else $error("control write lost");

    a_enable_write: assert property (@(posedge clk) disable iff (!rstn)
        wr && addr == ENABLE_BASE_OFS + 4'(NUM_FLAG_REGS - 1)
        |=> st_ff.enable[3] == ($past(wdata) & IMPL_MASK[3]))
        else $error("timer enable write lost");

    a_reset_regs: assert property (@(posedge clk)
        !rstn |=> st_ff.enable == '0 && st_ff.control == CONTROL_RESET && rdata == 8'h00)
        else $error("registers not cleared by reset");

    a_sw_set: assert property (@(posedge clk) disable iff (!rstn)
        wr && addr == TIMER_EVENT_FLAGS_OFS
        |=> (st_ff.flag[3] & $past(wdata) & STICKY_MASK[3]) == ($past(wdata) & STICKY_MASK[3]))
        else $error("timer flag write not taken");

endmodule : peripheral_irq_flag_bank

// File: tb/uart_buf_model.sv
`timescale 1ns/10ps
module uart_buf_model #(
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic rx_push,
    input wire logic rx_pop,
    input wire logic tx_load,
    input wire logic tx_drain,
    output logic rx_not_empty,
    output logic tx_has_space,
    output logic shift_empty
);
    int rx_cnt;
    int tx_cnt;
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rx_cnt <= 0;
            tx_cnt <= 0;
        end
        else
        begin
            rx_cnt <= rx_cnt + int'(rx_push && rx_cnt < DEPTH) - int'(rx_pop && rx_cnt > 0);
            // a load into a full buffer is dropped, as software must not send one
            tx_cnt <= tx_cnt + int'(tx_load && tx_cnt < DEPTH) - int'(tx_drain && tx_cnt > 0);
        end
    end
    assign rx_not_empty = rx_cnt != 0;
    assign tx_has_space = tx_cnt < DEPTH;
    // the shifter counts in tx_cnt, so space can show while the line is still busy
    assign shift_empty = tx_cnt == 0;
endmodule : uart_buf_model

// File: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    import irq_flag_pkg::*;
    localparam int EV_REG [12] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3};
    localparam int EV_BIT [12] = '{7, 6, 0, 6, 1, 0, 3, 2, 1, 0, 1, 0};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    // events in 11:0, then rx push, rx pop, tx load, tx drain per uart
    logic [19:0] stim = 20'h00000;
    logic [1:0] rx_ne;
    logic [1:0] tx_sp;
    logic [1:0] sh_e;
    logic [7:0] rdata;
    logic irq;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    peripheral_irq_flag_bank u_peripheral_irq_flag_bank (.clk(clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .osc_failsafe_event(stim[0]),
        .clock_switch_ready(stim[1]), .conversion_done(stim[2]), .zero_cross_event(stim[3]),
        .comparator_two_event(stim[4]), .comparator_one_event(stim[5]),
        .uart_two_rx_not_empty(rx_ne[1]), .uart_two_tx_has_space(tx_sp[1]),
        .uart_one_rx_not_empty(rx_ne[0]), .uart_one_tx_has_space(tx_sp[0]),
        .uart_two_shift_empty(sh_e[1]), .uart_one_shift_empty(sh_e[0]),
        .sync_two_collision(stim[6]), .sync_two_done(stim[7]), .sync_one_collision(stim[8]),
        .sync_one_done(stim[9]), .timer_two_event(stim[10]), .timer_one_overflow(stim[11]),
        .periph_irq_req(irq));
    for (genvar i = 0; i < 2; i++)
    begin : g_uart
        uart_buf_model u_uart_buf_model (.clk(clk), .rstn(rstn), .rx_push(stim[12+i]),
            .rx_pop(stim[14+i]), .tx_load(stim[16+i]), .tx_drain(stim[18+i]),
            .rx_not_empty(rx_ne[i]), .tx_has_space(tx_sp[i]), .shift_empty(sh_e[i]));
    end
    task automatic end_sim;
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            end_sim();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk
    task automatic pulse(input int b);
        @(posedge clk);
        stim[b] <= 1'b1;
        @(posedge clk);
        stim <= 20'h00000;
    endtask : pulse
    // both transmit buffers start empty, so their space bits read high
    function automatic logic [7:0] base(input int r);
        return (r == 2) ? 8'h50 : 8'h00;
    endfunction : base
    task automatic t_reset;
        for (int a = 0; a < 10; a++)
            rd_chk(a[3:0], (a == 9) ? 8'h03 : base(a));
        rd_chk(4'hA, 8'h00);
    endtask : t_reset
    task automatic ev_chk(input int i);
        pulse(i);
        rd_chk(EV_REG[i][3:0], (8'h01 << EV_BIT[i]) | base(EV_REG[i]));
        wr_reg(EV_REG[i][3:0], 8'h00);
        rd_chk(EV_REG[i][3:0], base(EV_REG[i]));
    endtask : ev_chk
    task automatic t_events;
        ev_chk(0);
        ev_chk(1);
        ev_chk(2);
        ev_chk(3);
        ev_chk(4);
        ev_chk(5);
        ev_chk(6);
        ev_chk(7);
        ev_chk(8);
        ev_chk(9);
        ev_chk(10);
        ev_chk(11);
    endtask : t_events
    task automatic t_write;
        for (int a = 0; a < 4; a++)
        begin
            wr_reg(a[3:0], 8'hFF);
            rd_chk(a[3:0], STICKY_MASK[a] | base(a));
            wr_reg(a[3:0], 8'h00);
        end
    endtask : t_write
    task automatic t_race;
        @(posedge clk);
        stim[2] <= 1'b1;
        addr <= 4'h0;
        wdata <= 8'h00;
        wr <= 1'b1;
        @(posedge clk);
        stim <= 20'h00000;
        wr <= 1'b0;
        rd_chk(4'h0, 8'h01);
        wr_reg(4'h0, 8'h00);
    endtask : t_race
    task automatic t_uart;
        pulse(13);
        rd_chk(4'h2, 8'hD0);
        wr_reg(4'h2, 8'h00);
        rd_chk(4'h2, 8'hD0);
        pulse(16);
        pulse(16);
        rd_chk(4'h2, 8'hC0);
        pulse(18);
        rd_chk(4'h2, 8'hD0);
        rd_chk(4'h9, 8'h02);
        pulse(15);
        rd_chk(4'h2, 8'h50);
        pulse(18);
        rd_chk(4'h9, 8'h03);
    endtask : t_uart
    task automatic t_irq;
        wr_reg(4'h8, 8'hC0);
        pulse(11);
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, irq}, 8'h00);
        wr_reg(4'h3, 8'h00);
        wr_reg(4'h7, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, irq}, 8'h00);
        pulse(11);
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, irq}, 8'h01);
        wr_reg(4'h8, 8'h80);
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, irq}, 8'h00);
        wr_reg(4'h3, 8'h00);
        wr_reg(4'h7, 8'h00);
    endtask : t_irq
    task automatic t_mid_reset;
        pulse(2);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(4'h0, 8'h00);
        rd_chk(4'h8, 8'h00);
    endtask : t_mid_reset
    initial
    begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_events();
        t_write();
        t_race();
        t_uart();
        t_irq();
        t_mid_reset();
        end_sim();
    end
endmodule : testbench
